// file: bench/bcq_bus_unit_model.sv
// partner model: bus unit and cache hierarchy issuing lookup and allocation reports
`timescale 1ns/100ps
`default_nettype none
module bcq_bus_unit_model import bcq_pkg::*; (
	// clock, reset and traffic gate
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	// lookup report
	output logic ref_valid,
	output logic ref_level_l3,
	output logic ref_load,
	output logic ref_read_for_ownership,
	output logic ref_writeback,
	output logic ref_hit,
	output bcq_coh_type ref_state,
	// allocation report
	output logic alloc_valid,
	output logic [AM_REQ_W-1:0] alloc_req_type,
	output logic alloc_read,
	output logic alloc_write,
	output logic [2:0] alloc_mem_type,
	output logic alloc_own_agent,
	output logic alloc_prefetch
);
	integer seed = 32'h1580;
	logic [31:0] v;
	logic [31:0] a;
	// fresh fields every cycle except while an allocation retry holds its fields, so an idle report never repeats its last value
	always @(posedge clk or negedge rstn) begin
		v = rstn ? $random(seed) : 32'h0;
		a = rstn ? $random(seed) : 32'h0;
		ref_valid <= rstn & run & v[0];
		ref_level_l3 <= v[1];
		ref_load <= v[2];
		ref_read_for_ownership <= v[3];
		ref_writeback <= v[4];
		ref_hit <= v[5];
		ref_state <= bcq_coh_type'(v[7:6]);
		// a retried request comes back unchanged; sector or chunk looks alike here
		if (rstn && run && alloc_valid && a[0]) begin
			alloc_valid <= 1'b1;
		end else begin
			alloc_valid <= rstn & run & a[1];
			alloc_req_type <= a[6:2];
			alloc_read <= a[7];
			alloc_write <= a[8];
			alloc_mem_type <= a[11:9];
			alloc_own_agent <= a[12];
			alloc_prefetch <= a[13];
		end
	end
endmodule : bcq_bus_unit_model
`default_nettype wire

// file: bench/tb_bus_cache_event_qualifier.sv
// self-checking bench of the bus cache event qualifier
`timescale 1ns/100ps
`default_nettype none
module tb_bus_cache_event_qualifier import bcq_pkg::*;;
	//============================================================
	// signals
	logic clk = 1'b0, rstn = 1'b0, run = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cache_ref_event, alloc_event;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic ref_valid, ref_level_l3, ref_load, ref_read_for_ownership, ref_writeback, ref_hit;
	bcq_coh_type ref_state;
	logic alloc_valid, alloc_read, alloc_write, alloc_own_agent, alloc_prefetch;
	logic [4:0] alloc_req_type;
	logic [2:0] alloc_mem_type;
	logic [10:0] cm = 11'h000;
	logic [15:0] am = 16'h0000;
	logic en = 1'b0, ec = 1'b0, ea = 1'b0;
	logic [31:0] rd;
	logic [1:0] rs;
	int cnt_c = 0, cnt_a = 0, err_total = 0, checks_done = 0;
	integer seed = 32'h1580;
	logic [15:0] atab [6] = '{16'h2020, 16'h4040, 16'h6180, 16'h200c, 16'h6160, 16'ha020};

	bcq_top dut_u (.clk(clk), .rstn(rstn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.ref_valid(ref_valid), .ref_level_l3(ref_level_l3), .ref_load(ref_load),
		.ref_read_for_ownership(ref_read_for_ownership), .ref_writeback(ref_writeback),
		.ref_hit(ref_hit), .ref_state(ref_state),
		.alloc_valid(alloc_valid), .alloc_req_type(alloc_req_type), .alloc_read(alloc_read), .alloc_write(alloc_write),
		.alloc_mem_type(alloc_mem_type), .alloc_own_agent(alloc_own_agent), .alloc_prefetch(alloc_prefetch),
		.cache_ref_event(cache_ref_event), .alloc_event(alloc_event));

	bcq_bus_unit_model bus_u (.clk(clk), .rstn(rstn), .run(run),
		.ref_valid(ref_valid), .ref_level_l3(ref_level_l3), .ref_load(ref_load),
		.ref_read_for_ownership(ref_read_for_ownership), .ref_writeback(ref_writeback),
		.ref_hit(ref_hit), .ref_state(ref_state),
		.alloc_valid(alloc_valid), .alloc_req_type(alloc_req_type), .alloc_read(alloc_read), .alloc_write(alloc_write),
		.alloc_mem_type(alloc_mem_type), .alloc_own_agent(alloc_own_agent), .alloc_prefetch(alloc_prefetch));

	//============================================================
	// expectations
	function automatic logic f_cache();
		logic rdt;
		logic [2:0] oh;
		rdt = ref_load | ref_read_for_ownership;
		oh = (ref_state == COH_INVALID) ? 3'h0 : 3'h1 << ref_state;
		return ref_valid & en & ((rdt & ref_hit & |(oh & (ref_level_l3 ? cm[5:3] : cm[2:0])))
			| (rdt & !ref_hit & (ref_level_l3 ? cm[9] : cm[8])) | (ref_writeback & !ref_hit & !ref_level_l3 & cm[10]));
	endfunction : f_cache
	function automatic logic f_alloc();
		logic f;
		f = ((am[4:0] == alloc_req_type) && am[4:0] > 5'h01) | am[5] & alloc_read | am[6] & alloc_write
			| am[7] & (alloc_mem_type == 3'h0) | am[8] & (alloc_mem_type == 3'h1);
		return alloc_valid & en & f & (am[13] & alloc_own_agent | am[14] & !alloc_own_agent)
			& !(alloc_read & alloc_prefetch & !am[15]);
	endfunction : f_alloc

	//============================================================
	// checking and bus tasks
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask : cmp_bit
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	// waits run until the answer; only the watchdog ends a dead handshake
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awd, wd;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		awd = 1'b0;
		wd = 1'b0;
		while (!(awd && wd)) begin
			@(posedge clk);
			if (!awd && s_axi_awready) begin
				awd = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		cmp_word({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
		end while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		// rready rises only after the address, so back-to-back reads never toggle it in one step
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		cmp_word(s_axi_rdata, ed);
		cmp_word({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : axi_rd
	// traffic only runs with masks settled; counts are cleared as the enable is written
	task automatic burst(input logic [31:0] c, input logic [31:0] a, input logic e, input int n);
		run <= 1'b0;
		repeat (3) @(posedge clk);
		axi_wr(ADDR_CACHE_MASK, c, RESP_OKAY);
		axi_wr(ADDR_ALLOC_MASK, a, RESP_OKAY);
		axi_wr(ADDR_CONTROL, {30'h0, 1'b1, e}, RESP_OKAY);
		cm = c[10:0];
		am = a[15:0];
		en = e;
		cnt_c = 0;
		cnt_a = 0;
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
		repeat (3) @(posedge clk);
		axi_rd(ADDR_CACHE_COUNT, 32'(cnt_c), RESP_OKAY);
		axi_rd(ADDR_ALLOC_COUNT, 32'(cnt_a), RESP_OKAY);
	endtask : burst

	//============================================================
	// clock, event monitor, watchdog and main sequence
	initial begin
		forever #4 clk = ~clk;
	end
	// events settle by the falling edge and answer the reports sampled one edge before
	always @(negedge clk) begin
		if (rstn) begin
			cmp_bit(cache_ref_event, ec);
			cmp_bit(alloc_event, ea);
			ec = f_cache();
			ea = f_alloc();
			cnt_c += ec;
			cnt_a += ea;
		end
	end
	initial begin
		#400000;
		err_total++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		axi_rd(ADDR_CACHE_MASK, 32'h0, RESP_OKAY);
		axi_rd(ADDR_ALLOC_MASK, 32'h0, RESP_OKAY);
		axi_rd(ADDR_CONTROL, 32'h0, RESP_OKAY);
		axi_wr(ADDR_EVENT_SELECT, 32'h0, RESP_SLVERR);
		axi_rd(ADDR_EVENT_SELECT, 32'h7, RESP_OKAY);
		axi_wr(8'h3c, 32'hffffffff, RESP_SLVERR);
		axi_rd(8'h3c, 32'h0, RESP_SLVERR);
		axi_wr(ADDR_CACHE_MASK, 32'hffffffff, RESP_OKAY);
		axi_rd(ADDR_CACHE_MASK, 32'h7ff, RESP_OKAY);
		// one cache mask bit at a time against a table of allocation field mixes
		for (int i = 0; i < 11; i++) begin
			burst(32'h1 << i, {16'h0, atab[i % 6]}, 1'b1, 300);
		end
		for (int i = 0; i < 8; i++) begin
			burst($random(seed), $random(seed) | 32'h2000, 1'b1, 300);
		end
		burst(32'h7ff, 32'hffff, 1'b0, 100);
		conclude();
	end
endmodule : tb_bus_cache_event_qualifier
`default_nettype wire

// file: pkg/bcq_pkg.sv
// package: register map, field layout and codes of the bus cache event qualifier
//============================================================
// Functional notes
// - cache mask bits 0-2: L2 read hit S/E/M
// - cache mask bits 3-5: L3 read hit S/E/M
// - bit 8 L2 read miss, bit 9 L3
// - bit 10: writeback lookup missing L2
// - loads and ownership reads both count as reads
// - classification follows the currently reported status
// - one pulse per matching bus queue allocation
// - sector or chunk entry counts once
// - every retry counts again
// - bits 0-4 form one request-type field
// - bits 7-8 select target memory type
// - bits 13-14 select the issuing agent
// - bit 15 affects read transactions only
// - (reqtype|bit5|bit6|memtype) and agent match
package bcq_pkg;
	//============================================================
	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CACHE_MASK = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ALLOC_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CACHE_COUNT = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_ALLOC_COUNT = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_SELECT = 8'h14;
	//============================================================
	// field layout
	localparam int CMASK_W = 11;
	localparam int AMASK_W = 16;
	localparam int CM_L2_HIT = 0;
	localparam int CM_L3_HIT = 3;
	localparam int CM_L2_MISS = 8;
	localparam int CM_WB_MISS = 10;
	localparam int AM_REQ_LSB = 0;
	localparam int AM_REQ_W = 5;
	localparam int AM_ALL_READ = 5;
	localparam int AM_ALL_WRITE = 6;
	localparam int AM_MEM_UC = 7;
	localparam int AM_MEM_WC = 8;
	localparam int AM_OWN = 13;
	localparam int AM_OTHER = 14;
	localparam int AM_PREFETCH = 15;
	localparam int CTL_ENABLE = 0;
	localparam int CTL_CLEAR = 1;
	//============================================================
	// reset values and codes
	localparam logic [CMASK_W-1:0] CACHE_MASK_RST = 11'h000;
	localparam logic [AMASK_W-1:0] ALLOC_MASK_RST = 16'h0000;
	localparam logic CONTROL_EN_RST = 1'b0;
	localparam logic [AM_REQ_W-1:0] REQ_TYPE_NONE = 5'h01;
	localparam logic [2:0] MEM_TYPE_UC = 3'h0;
	localparam logic [2:0] MEM_TYPE_WC = 3'h1;
	localparam logic [2:0] CACHE_REF_SELECT = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {COH_SHARED = 2'b00, COH_EXCLUSIVE = 2'b01, COH_MODIFIED = 2'b10,
		COH_INVALID = 2'b11} bcq_coh_type;
	typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} bcq_wr_state_type;
	//============================================================
	// coherence state to S/E/M select lines
	function automatic logic [2:0] bcq_coh_onehot(input bcq_coh_type s);
		case (s)
			COH_SHARED: return 3'h1;
			COH_EXCLUSIVE: return 3'h2;
			COH_MODIFIED: return 3'h4;
			default: return 3'h0;
		endcase
	endfunction : bcq_coh_onehot
	// word address compare, low two bits ignored
	function automatic logic bcq_word_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offs);
		return addr[ADDR_W-1:2] == offs[ADDR_W-1:2];
	endfunction : bcq_word_is
	// byte-lane merge of a write into an old value
	function automatic logic [31:0] bcq_strb_merge(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8 * b +: 8] = new_val[8 * b +: 8];
			end
		end
		return res;
	endfunction : bcq_strb_merge
endpackage : bcq_pkg

// file: pkg/bcq_qual_if.sv
// interface carrying masks and match results between the top and its qualifiers
`timescale 1ns/100ps
`default_nettype none
interface bcq_qual_if import bcq_pkg::*; ();
	logic [CMASK_W-1:0] cache_mask;
	logic [AMASK_W-1:0] alloc_mask;
	logic cache_match;
	logic alloc_match;
	modport cache_q (input cache_mask, output cache_match);
	modport alloc_q (input alloc_mask, output alloc_match);
endinterface : bcq_qual_if
`default_nettype wire

// file: verilog/bcq_alloc_qual.sv
// bus queue allocation qualifier: one allocation against the request-type, read, write, memory-type, agent and prefetch mask fields
`timescale 1ns/100ps
`default_nettype none
module bcq_alloc_qual import bcq_pkg::*; (
	// mask in, match out
	bcq_qual_if.alloc_q qif,
	// allocation report
	input wire logic alloc_valid,
	input wire logic [AM_REQ_W-1:0] alloc_req_type,
	input wire logic alloc_read,
	input wire logic alloc_write,
	input wire logic [2:0] alloc_mem_type,
	input wire logic alloc_own_agent,
	input wire logic alloc_prefetch
);
	logic [AMASK_W-1:0] mask;
	logic [AM_REQ_W-1:0] req_field;
	logic req_match;
	logic mem_match;
	logic agent_match;
	logic read_ok;
	logic expr;
	assign mask = qif.alloc_mask;
	assign req_field = mask[AM_REQ_LSB +: AM_REQ_W];
	// one value, not five flags; zero and the default code select nothing
	assign req_match = (req_field != REQ_TYPE_NONE) && (req_field != '0) && (alloc_req_type == req_field);
	assign mem_match = (mask[AM_MEM_UC] & (alloc_mem_type == MEM_TYPE_UC)) |
		(mask[AM_MEM_WC] & (alloc_mem_type == MEM_TYPE_WC));
	assign agent_match = (mask[AM_OWN] & alloc_own_agent) | (mask[AM_OTHER] & ~alloc_own_agent);
	// prefetch filter leaves writes and other types untouched
	assign read_ok = ~alloc_read | ~alloc_prefetch | mask[AM_PREFETCH];
	assign expr = (req_match | (mask[AM_ALL_READ] & alloc_read) | (mask[AM_ALL_WRITE] & alloc_write) | mem_match) &
		agent_match;
	// sector or chunk alike, and a retry arrives as a fresh allocation
	assign qif.alloc_match = alloc_valid & expr & read_ok;
endmodule : bcq_alloc_qual
`default_nettype wire

// file: verilog/bcq_cache_qual.sv
// cache reference qualifier: one bus unit lookup report against the cache mask
`timescale 1ns/100ps
`default_nettype none
module bcq_cache_qual import bcq_pkg::*; (
	// mask in, match out
	bcq_qual_if.cache_q qif,
	// lookup report
	input wire logic ref_valid,
	input wire logic ref_level_l3,
	input wire logic ref_load,
	input wire logic ref_read_for_ownership,
	input wire logic ref_writeback,
	input wire logic ref_hit,
	input wire bcq_coh_type ref_state
);
	logic read_type;
	logic [1:0] lvl_sel;
	logic [1:0] hit_sel;
	logic [1:0] miss_sel;
	logic [2:0] coh_sel;
	logic wb_miss;
	// loads and ownership reads are both read accesses
	assign read_type = ref_load | ref_read_for_ownership;
	assign lvl_sel = ref_level_l3 ? 2'h2 : 2'h1;
	assign coh_sel = bcq_coh_onehot(ref_state);
	// one hit and one miss term per cache level
	for (genvar lv = 0; lv < 2; lv++) begin : g_level
		assign hit_sel[lv] = lvl_sel[lv] & read_type & ref_hit &
			(|(coh_sel & qif.cache_mask[CM_L2_HIT + (CM_L3_HIT - CM_L2_HIT) * lv +: 3]));
		assign miss_sel[lv] = lvl_sel[lv] & read_type & ~ref_hit & qif.cache_mask[CM_L2_MISS + lv];
	end
	assign wb_miss = lvl_sel[0] & ref_writeback & ~ref_hit & qif.cache_mask[CM_WB_MISS];
	// no copy of the status is kept, so a late change of hit or coherence state is followed
	assign qif.cache_match = ref_valid & ((|hit_sel) | (|miss_sel) | wb_miss);
endmodule : bcq_cache_qual
`default_nettype wire

// file: verilog/bcq_top.sv
// top of the bus cache event qualifier: register slave, qualifiers, counts and events
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module bcq_top import bcq_pkg::*; #(
	parameter int COUNT_W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// cache reference report from the bus unit
	input wire logic ref_valid,
	input wire logic ref_level_l3,
	input wire logic ref_load,
	input wire logic ref_read_for_ownership,
	input wire logic ref_writeback,
	input wire logic ref_hit,
	input wire bcq_coh_type ref_state,
	// bus queue allocation report
	input wire logic alloc_valid,
	input wire logic [AM_REQ_W-1:0] alloc_req_type,
	input wire logic alloc_read,
	input wire logic alloc_write,
	input wire logic [2:0] alloc_mem_type,
	input wire logic alloc_own_agent,
	input wire logic alloc_prefetch,
	// qualified events toward the counters
	output logic cache_ref_event,
	output logic alloc_event
);
	//============================================================
	// elaboration check
	if (COUNT_W < 1 || COUNT_W > 32) begin : g_count_w_check
		$error("COUNT_W must lie in 1..32");
	end

	//============================================================
	// state
	logic [CMASK_W-1:0] cache_mask_reg;
	logic [AMASK_W-1:0] alloc_mask_reg;
	logic enable_reg;
	logic clear_reg;
	logic [COUNT_W-1:0] cache_cnt_reg;
	logic [COUNT_W-1:0] cache_cnt_next;
	logic [COUNT_W-1:0] alloc_cnt_reg;
	logic [COUNT_W-1:0] alloc_cnt_next;
	logic cache_event_reg;
	logic alloc_event_reg;
	bcq_wr_state_type wr_state_reg;
	bcq_wr_state_type wr_state_next;
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	//============================================================
	// qualifiers
	bcq_qual_if qif ();
	assign qif.cache_mask = cache_mask_reg;
	assign qif.alloc_mask = alloc_mask_reg;

	bcq_cache_qual u_cache_qual (
		.qif(qif.cache_q),
		.ref_valid(ref_valid),
		.ref_level_l3(ref_level_l3),
		.ref_load(ref_load),
		.ref_read_for_ownership(ref_read_for_ownership),
		.ref_writeback(ref_writeback),
		.ref_hit(ref_hit),
		.ref_state(ref_state)
	);

	bcq_alloc_qual u_alloc_qual (
		.qif(qif.alloc_q),
		.alloc_valid(alloc_valid),
		.alloc_req_type(alloc_req_type),
		.alloc_read(alloc_read),
		.alloc_write(alloc_write),
		.alloc_mem_type(alloc_mem_type),
		.alloc_own_agent(alloc_own_agent),
		.alloc_prefetch(alloc_prefetch)
	);

	//============================================================
	// write channel decode
	logic wr_idle;
	logic aw_fire;
	logic w_fire;
	logic wr_commit;
	logic wr_cmask;
	logic wr_amask;
	logic wr_ctl;
	logic [31:0] cmask_merged;
	logic [31:0] amask_merged;
	logic [31:0] ctl_merged;
	// address and data are caught separately, so either may come first
	assign wr_idle = (wr_state_reg == WR_IDLE);
	assign s_axi_awready = ~aw_held_reg & wr_idle;
	assign s_axi_wready = ~w_held_reg & wr_idle;
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire = s_axi_wvalid & s_axi_wready;
	assign wr_commit = aw_held_reg & w_held_reg & wr_idle;
	assign wr_cmask = wr_commit & bcq_word_is(aw_addr_reg, ADDR_CACHE_MASK);
	assign wr_amask = wr_commit & bcq_word_is(aw_addr_reg, ADDR_ALLOC_MASK);
	assign wr_ctl = wr_commit & bcq_word_is(aw_addr_reg, ADDR_CONTROL);
	assign cmask_merged = bcq_strb_merge(32'(cache_mask_reg), w_data_reg, w_strb_reg);
	assign amask_merged = bcq_strb_merge(32'(alloc_mask_reg), w_data_reg, w_strb_reg);
	assign ctl_merged = bcq_strb_merge(32'(enable_reg), w_data_reg, w_strb_reg);

	// response state
	always_comb begin
		case (wr_state_reg)
			WR_IDLE: wr_state_next = wr_commit ? WR_RESP : WR_IDLE;
			WR_RESP: wr_state_next = s_axi_bready ? WR_IDLE : WR_RESP;
			default: wr_state_next = WR_IDLE;
		endcase
	end

	// address and data holding
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			aw_held_reg <= aw_fire | (aw_held_reg & ~wr_commit);
			w_held_reg <= w_fire | (w_held_reg & ~wr_commit);
			if (aw_fire) aw_addr_reg <= s_axi_awaddr;
			if (w_fire) w_data_reg <= s_axi_wdata;
			if (w_fire) w_strb_reg <= s_axi_wstrb;
		end
	end

	// response; writes to read-only or unmapped words answer with an error
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_state_reg <= WR_IDLE;
			bresp_reg <= RESP_OKAY;
		end else begin
			wr_state_reg <= wr_state_next;
			if (wr_commit) bresp_reg <= (wr_cmask | wr_amask | wr_ctl) ? RESP_OKAY : RESP_SLVERR;
		end
	end
	assign s_axi_bvalid = (wr_state_reg == WR_RESP);
	assign s_axi_bresp = bresp_reg;

	//============================================================
	// software registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cache_mask_reg <= CACHE_MASK_RST;
			alloc_mask_reg <= ALLOC_MASK_RST;
			enable_reg <= CONTROL_EN_RST;
			clear_reg <= 1'b0;
		end else begin
			if (wr_cmask) cache_mask_reg <= cmask_merged[CMASK_W-1:0];
			if (wr_amask) alloc_mask_reg <= amask_merged[AMASK_W-1:0];
			if (wr_ctl) enable_reg <= ctl_merged[CTL_ENABLE];
			clear_reg <= wr_ctl & ctl_merged[CTL_CLEAR]; // self-clearing pulse
		end
	end

	//============================================================
	// counts and events
	logic cache_fire;
	logic alloc_fire;
	assign cache_fire = enable_reg & qif.cache_match;
	assign alloc_fire = enable_reg & qif.alloc_match;
	// a clear colliding with an event keeps that event
	assign cache_cnt_next = clear_reg ? COUNT_W'(cache_fire) : cache_cnt_reg + COUNT_W'(cache_fire);
	assign alloc_cnt_next = clear_reg ? COUNT_W'(alloc_fire) : alloc_cnt_reg + COUNT_W'(alloc_fire);

	// events are registered so the counters see clean pulses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cache_cnt_reg <= '0;
			alloc_cnt_reg <= '0;
			cache_event_reg <= 1'b0;
			alloc_event_reg <= 1'b0;
		end else begin
			cache_cnt_reg <= cache_cnt_next;
			alloc_cnt_reg <= alloc_cnt_next;
			cache_event_reg <= cache_fire;
			alloc_event_reg <= alloc_fire;
		end
	end
	assign cache_ref_event = cache_event_reg;
	assign alloc_event = alloc_event_reg;

	//============================================================
	// read channel
	logic rd_cmask;
	logic rd_amask;
	logic rd_ctl;
	logic rd_ccnt;
	logic rd_acnt;
	logic rd_sel;
	logic rd_mapped;
	logic [31:0] rd_mux;
	assign rd_cmask = bcq_word_is(s_axi_araddr, ADDR_CACHE_MASK);
	assign rd_amask = bcq_word_is(s_axi_araddr, ADDR_ALLOC_MASK);
	assign rd_ctl = bcq_word_is(s_axi_araddr, ADDR_CONTROL);
	assign rd_ccnt = bcq_word_is(s_axi_araddr, ADDR_CACHE_COUNT);
	assign rd_acnt = bcq_word_is(s_axi_araddr, ADDR_ALLOC_COUNT);
	assign rd_sel = bcq_word_is(s_axi_araddr, ADDR_EVENT_SELECT);
	assign rd_mapped = rd_cmask | rd_amask | rd_ctl | rd_ccnt | rd_acnt | rd_sel;
	// clear bit reads as zero; unmapped words read zero
	assign rd_mux = rd_cmask ? 32'(cache_mask_reg) :
		rd_amask ? 32'(alloc_mask_reg) :
		rd_ctl ? 32'(enable_reg) :
		rd_ccnt ? 32'(cache_cnt_reg) :
		rd_acnt ? 32'(alloc_cnt_reg) :
		rd_sel ? 32'(CACHE_REF_SELECT) : 32'h0000_0000;
	assign s_axi_arready = ~rvalid_reg;

	// one read in flight; data held until rready
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	//============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic agent_ok;
	logic pref_ok;
	assign agent_ok = (alloc_mask_reg[AM_OWN] & alloc_own_agent) | (alloc_mask_reg[AM_OTHER] & ~alloc_own_agent);
	assign pref_ok = ~alloc_read | ~alloc_prefetch | alloc_mask_reg[AM_PREFETCH];

	a_l2_hit_shared: assert property (
		ref_valid && enable_reg && !ref_level_l3 && ref_load && ref_hit && ref_state == COH_SHARED &&
		cache_mask_reg[CM_L2_HIT] |=> cache_ref_event)
		else $error("l2 shared read hit not counted");
	a_l3_hit_mod: assert property (
		ref_valid && enable_reg && ref_level_l3 && ref_load && ref_hit && ref_state == COH_MODIFIED &&
		cache_mask_reg[CM_L3_HIT + 2] |=> cache_ref_event)
		else $error("l3 modified read hit not counted");
	a_l2_miss_only: assert property (
		ref_valid && enable_reg && !ref_level_l3 && !ref_hit && !ref_writeback &&
		cache_mask_reg == CMASK_W'(1 << CM_L2_MISS) |=> cache_ref_event == $past(ref_load || ref_read_for_ownership))
		else $error("l2 read miss counted wrongly");
	a_wb_miss: assert property (
		ref_valid && enable_reg && !ref_level_l3 && ref_writeback && !ref_hit &&
		cache_mask_reg[CM_WB_MISS] |=> cache_ref_event)
		else $error("writeback lookup miss not counted");
	a_own_read_hit: assert property (
		ref_valid && enable_reg && ref_level_l3 && ref_read_for_ownership && !ref_load && ref_hit &&
		ref_state == COH_EXCLUSIVE && cache_mask_reg[CM_L3_HIT + 1] |=> cache_ref_event)
		else $error("ownership read not taken as read");
	a_alloc_count: assert property (
		alloc_fire && !clear_reg |=> alloc_event && alloc_cnt_reg == COUNT_W'($past(alloc_cnt_reg) + 1'b1))
		else $error("allocation count did not step by one");
	a_prefetch_gate: assert property (
		alloc_valid && alloc_read && alloc_prefetch && !alloc_mask_reg[AM_PREFETCH] |=> !alloc_event)
		else $error("filtered prefetch read counted");
	a_agent_gate: assert property (
		alloc_valid && !agent_ok |=> !alloc_event)
		else $error("allocation counted without agent match");
	a_mem_uc: assert property (
		alloc_valid && enable_reg && alloc_mem_type == MEM_TYPE_UC && alloc_mask_reg[AM_MEM_UC] &&
		agent_ok && pref_ok |=> alloc_event)
		else $error("uncached allocation not counted");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
		else $error("read not answered in one cycle");

	c_cache_event: cover property (cache_ref_event);
	c_alloc_event: cover property (alloc_event ##1 alloc_event);
	c_write_done: cover property (wr_commit ##1 s_axi_bvalid && s_axi_bready);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule : bcq_top
`default_nettype wire
